//--- dv/ulsf_host_model.sv
// Host model issuing register reads and writes
`timescale 1ns/1ps
module ulsf_host_model
   import ulsf_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] rdata,
   output ulsf_bus_req_t   bus_req
);
   initial bus_req = '0;
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk);
      bus_req <= '0;
   endtask
   // Read data stands one cycle only, so take it right after the edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk);
      bus_req <= '0;
      #1 d = rdata;
   endtask
endmodule // ulsf_host_model

//--- dv/ulsf_line_status_tb.sv
// Self-checking bench for the line status flags
`timescale 1ns/1ps
module ulsf_line_status_tb
   import ulsf_pkg::*;
;
   logic          sys_clk = 1'b0;
   logic          rstn = 1'b0;
   ulsf_bus_req_t bus_req;
   logic [7:0]    rdata, d, tx_fifo_level = 8'h00;
   logic          irq, brk_push, esum, idle;
   logic          fifo_mode = 1'b0, rx_push = 1'b0, rx_pop = 1'b0;
   logic          rx_line = 1'b1, tx_holding_full = 1'b0, tx_shift_busy = 1'b0;
   ulsf_rx_tag_t  rx_push_tag = '0;
   int            fails = 0, n_compared = 0;
   always #5 sys_clk = ~sys_clk;
   ulsf_host_model i_ulsf_host_model (.sys_clk(sys_clk), .rdata(rdata),
      .bus_req(bus_req));
   ulsf_line_status #(.FRAME_W(16)) i_ulsf_line_status (
      .sys_clk(sys_clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
      .irq(irq), .fifo_mode(fifo_mode), .rx_push(rx_push),
      .rx_push_tag(rx_push_tag), .rx_pop(rx_pop), .rx_line(rx_line),
      .frame_ticks(16'h0004), .tx_holding_full(tx_holding_full),
      .tx_fifo_level(tx_fifo_level), .tx_shift_busy(tx_shift_busy),
      .brk_push(brk_push), .rx_fifo_error_summary(esum),
      .transmitter_idle(idle));
   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         fails++;
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic push(ulsf_rx_tag_t t);
      @(posedge sys_clk);
      rx_push <= 1'b1;
      rx_push_tag <= t;
      @(posedge sys_clk);
      rx_push <= 1'b0;
   endtask
   task automatic pop();
      @(posedge sys_clk);
      rx_pop <= 1'b1;
      @(posedge sys_clk);
      rx_pop <= 1'b0;
   endtask
   task automatic t_reset();
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      step(4);
      check("idle_rst", {7'h0, idle}, 8'h01);
      check("sum_rst", {7'h0, esum}, 8'h00);
   endtask
   // Error kept at the middle entry, clean entries on both sides
   task automatic t_rx_err();
      for (int k = 0; k < 3; k++) begin
         push('0);
         push(ulsf_rx_tag_t'(3'h1 << k));
         push('0);
         step(1);
         check("sum_held", {7'h0, esum}, 8'h01);
         pop();
         step(1);
         check("sum_clean_pop", {7'h0, esum}, 8'h01);
         pop();
         step(1);
         check("sum_err_pop", {7'h0, esum}, 8'h00);
         pop();
      end
   endtask
   // Level stays zero outside FIFO mode, as a real unit would
   task automatic t_tx_idle();
      logic [3:0] c;
      logic       e;
      for (int k = 0; k < 17; k++) begin
         c = k[3:0];
         @(posedge sys_clk);
         fifo_mode <= c[3] && k < 16;
         tx_holding_full <= c[2] && k < 16;
         tx_shift_busy <= c[1] && k < 16;
         tx_fifo_level <= (c[3] && c[0] && k < 16) ? 8'h80 : 8'h00;
         step(1);
         e = k == 16 || (!c[1] && (c[3] ? !c[0] : !c[2]));
         check("idle", {7'h0, idle}, {7'h0, e});
      end
   endtask
   task automatic t_regs_irq();
      i_ulsf_host_model.wr(4'h0, 8'hff);
      i_ulsf_host_model.rd(4'h0, d);
      check("ls_after_wr", d, 8'h40);
      i_ulsf_host_model.rd(4'h5, d);
      check("unmapped", d, 8'h00);
      i_ulsf_host_model.wr(4'h1, 8'hff);
      i_ulsf_host_model.wr(4'h2, 8'h01);
      i_ulsf_host_model.rd(4'h2, d);
      check("irq_mask", d, 8'h01);
      push('{brk: 1'b0, framing: 1'b0, parity: 1'b1});
      step(2);
      check("irq_set", {7'h0, irq}, 8'h01);
      i_ulsf_host_model.wr(4'h3, 8'h00);
      i_ulsf_host_model.rd(4'h3, d);
      check("err_count", d, 8'h01);
      i_ulsf_host_model.rd(4'h0, d);
      check("ls_err", d, 8'hc0);
      i_ulsf_host_model.rd(4'h0, d);
      check("ls_reread", d, 8'hc0);
      i_ulsf_host_model.wr(4'h1, 8'h01);
      step(2);
      check("irq_clr", {7'h0, irq}, 8'h00);
      i_ulsf_host_model.wr(4'h2, 8'h00);
      pop();
   endtask
   // Line held low far past one frame must still yield one break char
   task automatic t_break();
      int cnt;
      cnt = 0;
      @(posedge sys_clk);
      rx_line <= 1'b0;
      for (int k = 0; k < 30; k++) begin
         step(1);
         cnt += brk_push;
      end
      check("brk_count", cnt[7:0], 8'h01);
      @(posedge sys_clk);
      rx_line <= 1'b1;
      // Only the break event is left pending in the status
      i_ulsf_host_model.rd(4'h1, d);
      check("irq_brk", d, 8'h04);
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      t_reset();
      t_rx_err();
      t_tx_idle();
      t_regs_irq();
      t_break();
      end_sim();
   end
endmodule // ulsf_line_status_tb

//--- pkg/ulsf_params.svh
// Constants for the line status flag block
`ifndef ULSF_PARAMS_SVH
`define ULSF_PARAMS_SVH
`define ULSF_OFF_LINE_STATUS  4'h0
`define ULSF_OFF_IRQ_STATUS   4'h1
`define ULSF_OFF_IRQ_MASK     4'h2
`define ULSF_OFF_ERR_COUNT    4'h3
`define ULSF_BIT_ERR_SUMMARY  7
`define ULSF_BIT_TX_IDLE      6
`define ULSF_IRQ_BIT_ERR_SET  0
`define ULSF_IRQ_BIT_TX_IDLE  1
`define ULSF_IRQ_BIT_BREAK    2
`define ULSF_RST_IRQ_MASK     8'h00
`endif

//--- pkg/ulsf_pkg.sv
// Types for the line status flag block
package ulsf_pkg;
   // Error tags carried with one receive character
   typedef struct packed {
      logic brk;
      logic framing;
      logic parity;
   } ulsf_rx_tag_t;
   // Register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } ulsf_bus_req_t;
   // Break detector states
   typedef enum logic [1:0] {
      ULSF_LINE_IDLE, ULSF_LINE_LOW, ULSF_LINE_HELD
   } ulsf_brk_state_t;
endpackage

//--- verilog/ulsf_break_detect.sv
// Break detector: one tag per frame-long low line
`timescale 1ns/1ps
module ulsf_break_detect
   import ulsf_pkg::*;
#(
   parameter int FRAME_W = 16
) (
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire logic               rx_line,
   input  wire logic [FRAME_W-1:0] frame_ticks,
   output logic                    brk_pulse
);
   ulsf_brk_state_t    state;
   ulsf_brk_state_t    next_state;
   logic [FRAME_W-1:0] cnt;
   logic [FRAME_W-1:0] next_cnt;
   logic               next_brk_pulse;

   always_comb begin
      next_state     = state;
      next_cnt       = cnt;
      next_brk_pulse = 1'b0;
      unique case (state)
         ULSF_LINE_IDLE: begin
            next_cnt = '0;
            if (!rx_line) begin
               next_state = ULSF_LINE_LOW;
            end
         end
         ULSF_LINE_LOW: begin
            if (rx_line) begin
               next_state = ULSF_LINE_IDLE;
            end else if (cnt + 1'b1 >= frame_ticks) begin
               next_state     = ULSF_LINE_HELD;
               next_brk_pulse = 1'b1;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         // Only one break character per low period
         ULSF_LINE_HELD: begin
            if (rx_line) begin
               next_state = ULSF_LINE_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ULSF_LINE_IDLE;
         cnt       <= '0;
         brk_pulse <= 1'b0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         brk_pulse <= next_brk_pulse;
      end
   end

   a_brk_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
      brk_pulse |=> !brk_pulse)
      else $error("break pulse longer than one cycle");
endmodule // ulsf_break_detect

//--- verilog/ulsf_line_status.sv
// Line status summary and transmitter idle flags
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "ulsf_params.svh"
module ulsf_line_status
   import ulsf_pkg::*;
#(
   parameter int DEPTH   = 128,
   parameter int FRAME_W = 16
) (
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   input  wire ulsf_bus_req_t      bus_req,
   output logic [7:0]              rdata,
   output logic                    irq,
   input  wire logic               fifo_mode,
   input  wire logic               rx_push,
   input  wire ulsf_rx_tag_t       rx_push_tag,
   input  wire logic               rx_pop,
   input  wire logic               rx_line,
   input  wire logic [FRAME_W-1:0] frame_ticks,
   input  wire logic               tx_holding_full,
   input  wire logic [7:0]         tx_fifo_level,
   input  wire logic               tx_shift_busy,
   output logic                    brk_push,
   output logic                    rx_fifo_error_summary,
   output logic                    transmitter_idle
);
   localparam int AW = $clog2(DEPTH);

   logic          rs1;
   logic          rst_n;
   ulsf_rx_tag_t  tag_mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0]   err_cnt;
   logic [AW:0]   next_err_cnt;
   logic          next_summary;
   logic          next_idle;
   logic          brk_pulse;
   logic          push_bad;
   logic          pop_bad;
   logic [7:0]    irq_status;
   logic [7:0]    irq_mask;
   logic [7:0]    next_irq_status;
   logic [7:0]    next_irq_mask;
   logic [7:0]    next_rdata;
   logic [7:0]    events;
   logic          prev_summary;
   logic          prev_idle;

   // Two-stage reset release
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rs1   <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1   <= 1'b1;
         rst_n <= rs1;
      end
   end

   ulsf_break_detect #(.FRAME_W(FRAME_W)) u_brk (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .rx_line     (rx_line),
      .frame_ticks (frame_ticks),
      .brk_pulse   (brk_pulse)
   );

   // Tag shadow of the receive FIFO; count of tagged entries
   assign push_bad = rx_push &
      (rx_push_tag.brk | rx_push_tag.framing | rx_push_tag.parity);
   assign pop_bad  = rx_pop &
      (tag_mem[rp].brk | tag_mem[rp].framing | tag_mem[rp].parity);

   always_ff @(posedge sys_clk) begin
      if (rx_push) begin
         tag_mem[wp] <= rx_push_tag;
      end
   end

   always_comb begin
      next_err_cnt = err_cnt;
      if (push_bad && !pop_bad) begin
         next_err_cnt = err_cnt + 1'b1;
      end else if (pop_bad && !push_bad) begin
         next_err_cnt = err_cnt - 1'b1;
      end
      next_summary = (next_err_cnt != '0);
   end

   always_comb begin
      if (fifo_mode) begin
         next_idle = (tx_fifo_level == 8'h00) && !tx_shift_busy;
      end else begin
         next_idle = !tx_holding_full && !tx_shift_busy;
      end
   end

   // Events: summary rise, idle rise, break seen
   always_comb begin
      events = 8'h00;
      events[`ULSF_IRQ_BIT_ERR_SET] = rx_fifo_error_summary & ~prev_summary;
      events[`ULSF_IRQ_BIT_TX_IDLE] = transmitter_idle & ~prev_idle;
      events[`ULSF_IRQ_BIT_BREAK]   = brk_pulse;
   end

   always_comb begin
      next_irq_status = irq_status;
      next_irq_mask   = irq_mask;
      next_rdata      = 8'h00;
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            `ULSF_OFF_IRQ_STATUS: next_irq_status = irq_status & ~bus_req.wdata;
            `ULSF_OFF_IRQ_MASK:   next_irq_mask   = bus_req.wdata;
            default:              next_irq_mask   = irq_mask;
         endcase
      end
      // Set wins over a same-cycle clear
      next_irq_status = next_irq_status | events;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            `ULSF_OFF_LINE_STATUS: begin
               next_rdata[`ULSF_BIT_ERR_SUMMARY] = rx_fifo_error_summary;
               next_rdata[`ULSF_BIT_TX_IDLE]     = transmitter_idle;
            end
            `ULSF_OFF_IRQ_STATUS: next_rdata = irq_status;
            `ULSF_OFF_IRQ_MASK:   next_rdata = irq_mask;
            `ULSF_OFF_ERR_COUNT:  next_rdata = 8'(err_cnt);
            default:              next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp                    <= '0;
         rp                    <= '0;
         err_cnt               <= '0;
         rx_fifo_error_summary <= 1'b0;
         transmitter_idle      <= 1'b1;
         prev_summary          <= 1'b0;
         prev_idle             <= 1'b1;
         irq_status            <= 8'h00;
         irq_mask              <= `ULSF_RST_IRQ_MASK;
         rdata                 <= 8'h00;
         irq                   <= 1'b0;
         brk_push              <= 1'b0;
      end else begin
         wp                    <= rx_push ? wp + 1'b1 : wp;
         rp                    <= rx_pop ? rp + 1'b1 : rp;
         err_cnt               <= next_err_cnt;
         rx_fifo_error_summary <= next_summary;
         transmitter_idle      <= next_idle;
         prev_summary          <= rx_fifo_error_summary;
         prev_idle             <= transmitter_idle;
         irq_status            <= next_irq_status;
         irq_mask              <= next_irq_mask;
         rdata                 <= next_rdata;
         irq                   <= |(next_irq_status & next_irq_mask);
         brk_push              <= brk_pulse;
      end
   end

   a_err_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (push_bad && !pop_bad) |=> rx_fifo_error_summary)
      else $error("summary not set after tagged push");

   a_err_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (err_cnt == '0) |-> !rx_fifo_error_summary)
      else $error("summary set with no tagged entries");

   a_idle_plain: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!fifo_mode && !tx_holding_full && !tx_shift_busy) |=> transmitter_idle)
      else $error("idle not set with both stages empty");

   a_idle_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tx_shift_busy |=> !transmitter_idle)
      else $error("idle set while shift stage busy");

   a_idle_fifo: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (fifo_mode && tx_fifo_level != 8'h00) |=> !transmitter_idle)
      else $error("idle set with transmit FIFO not empty");

   a_brk_push: assert property (@(posedge sys_clk) disable iff (!rst_n)
      brk_pulse |=> brk_push ##1 !brk_push)
      else $error("break push not one cycle after detect");

   a_ro_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (bus_req.wr && bus_req.addr == `ULSF_OFF_LINE_STATUS
       && !push_bad && !pop_bad) |=> $stable(rx_fifo_error_summary))
      else $error("write changed summary bit");

   // Interrupt level tracks masked status
   a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
      irq == |(irq_status & irq_mask))
      else $error("irq does not match masked status");
endmodule // ulsf_line_status
